// ---- logic/wdw_top.sv ----
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
`include "wdw_defines.svh"

// How it works
// R1: Enabled counter advances on low-power ticks; expiry without kick resets device.
// R2: Postscaler field selects timeout length as base period times two to ps, with ps above 20 acting as 20.
// R3: Expiry during Sleep or Idle wakes the device instead of resetting.
// R4: Writing on bit starts watchdog; zero stops only a software-enabled one.
// R5: On bit reads one whenever watchdog runs, by configuration or software.
// R6: Bits 6..2 read-only shadow of postscale configuration, reloaded each reset.
// R7: Bit 1 read/write window mode enable, reset zero.
// R8: Writing one to bit 0 kicks the counter; zero does nothing.
// R9: Control at offset zero; clear, set, invert aliases at 4, 8, C.
// R10: Bits 31..16 and 14..7 of control always read zero.
// R11: Software avoids register access the cycle after clearing on bit.
// R12: In window mode a kick before the window opens resets the device.
// R13: A kick also clears the postscaler, restarting a full period.
module wdw_top
  import wdw_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        cfg_enable,
  input  wire logic [4:0]  cfg_postscale,
  input  wire logic        low_power_rc_tick,
  input  wire logic        sleep_or_idle,
  output logic             device_reset_req,
  output logic             wake_req,
  output logic             irq
);

  // Alias write applied to the old control value
  function automatic logic [31:0] alias_apply(
    input wdw_alias_type al,
    input logic [31:0]   old_v,
    input logic [31:0]   wd
  );
    logic [31:0] r;
    r = old_v;
    case (al)
      WDW_AL_WR:  r = wd;
      WDW_AL_CLR: r = old_v & ~wd;
      WDW_AL_SET: r = old_v | wd;
      WDW_AL_INV: r = old_v ^ wd;
      default:    r = old_v;
    endcase
    return r;
  endfunction

  // Last postscale count of a period for a given field
  function automatic logic [`WDW_POST_W-1:0] post_limit(
    input logic [4:0] ps
  );
    logic [`WDW_POST_W-1:0] one;
    one = {{(`WDW_POST_W-1){1'b0}}, 1'b1};
    if (ps > `WDW_PS_CAP) begin
      return {`WDW_POST_W{1'b1}};
    end
    return (one << ps) - one;
  endfunction

  // State
  logic                   load_q;
  logic                   cfg_on_q;
  logic [4:0]             shadow_q;
  logic                   sw_on_q;
  logic                   win_q;
  logic [`WDW_PRE_W-1:0]  pre_q;
  logic [`WDW_POST_W-1:0] post_q;
  logic                   rst_q;
  logic                   wake_q;
  logic [`WDW_ST_W-1:0]   st_q;
  logic [`WDW_ST_W-1:0]   mask_q;
  logic [31:0]            rdata_q;
  logic [`WDW_ST_W-1:0]   rd_clr_q;

  // Bus decode
  wire setup_w  = clk_en & psel & ~penable;
  wire access_w = clk_en & psel & penable;
  wire hit_ctrl = paddr == `WDW_OFF_CTRL;
  wire hit_clr  = paddr == `WDW_OFF_CLR;
  wire hit_set  = paddr == `WDW_OFF_SET;
  wire hit_inv  = paddr == `WDW_OFF_INV;
  wire hit_stat = paddr == `WDW_OFF_STAT;
  wire hit_mask = paddr == `WDW_OFF_MASK;
  wire hit_al   = hit_clr | hit_set | hit_inv;
  wire hit_any  = hit_ctrl | hit_al | hit_stat | hit_mask;
  wire wr_w     = access_w & pwrite;
  wire ctrl_wr  = wr_w & (hit_ctrl | hit_al);
  // Aliases are write only, so reading them is refused
  wire bad_w    = ~hit_any | (~pwrite & hit_al);

  // Alias selection
  wdw_alias_type al_w;
  assign al_w = hit_clr ? WDW_AL_CLR :
                hit_set ? WDW_AL_SET :
                hit_inv ? WDW_AL_INV : WDW_AL_WR;

  // Control view and its updated value
  wire        on_w = cfg_on_q | sw_on_q; // R5
  wire [31:0] ctrl_rd;
  assign ctrl_rd = {16'h0000, on_w, 8'h00,
                    shadow_q, win_q, 1'b0}; // R10 R6
  wire [31:0] ctrl_nx = alias_apply(al_w, ctrl_rd, pwdata); // R9
  wire        kick_w  = ctrl_wr & ctrl_nx[`WDW_BIT_KICK]; // R8

  // Counter, window and expiry
  wire [`WDW_POST_W-1:0] lim_w = post_limit(shadow_q); // R2
  wire [`WDW_POST_W-1:0] open_w;
  assign open_w = lim_w - (lim_w >> `WDW_WIN_SHIFT);
  wire tick_w   = on_w & low_power_rc_tick;
  wire pwrap_w  = pre_q == `WDW_PRE_MAX;
  wire expire_w = tick_w & pwrap_w & (post_q == lim_w) & ~kick_w; // R1
  wire early_w  = kick_w & win_q & on_w & (post_q < open_w); // R12
  wire fire_w   = (expire_w & ~sleep_or_idle) | early_w;
  wire wake_w   = expire_w & sleep_or_idle; // R3
  wire [`WDW_ST_W-1:0] ev_w = {early_w, wake_w,
                               expire_w & ~sleep_or_idle};

  // Read data selection
  wire [31:0] rd_w;
  assign rd_w = hit_ctrl ? ctrl_rd :
                hit_stat ? {29'h0, st_q} :
                hit_mask ? {29'h0, mask_q} : 32'h0000_0000;

  // Configuration capture right after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_q   <= 1'b1;
      cfg_on_q <= 1'b0;
      shadow_q <= 5'h00;
    end else if (clk_en && load_q) begin
      load_q   <= 1'b0;
      cfg_on_q <= cfg_enable;
      shadow_q <= cfg_postscale; // R6
    end
  end

  // Software enable and window mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_on_q <= 1'b0;
      win_q   <= 1'b0; // R7
    end else if (ctrl_wr) begin
      sw_on_q <= ctrl_nx[`WDW_BIT_ON] & ~cfg_on_q; // R4
      win_q   <= ctrl_nx[`WDW_BIT_WIN]; // R7
    end
  end

  // Prescale and postscale counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q  <= `WDW_PRE_MAX;
      post_q <= {`WDW_POST_W{1'b0}};
    end else if (clk_en) begin
      if (!on_w || kick_w || expire_w) begin
        pre_q  <= {`WDW_PRE_W{1'b0}}; // R13
        post_q <= {`WDW_POST_W{1'b0}}; // R13
      end else if (tick_w) begin
        pre_q <= pre_q + 1'b1; // R1
        if (pwrap_w) begin
          post_q <= post_q + 1'b1;
        end
      end
    end
  end

  // Reset and wake pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_q  <= 1'b0;
      wake_q <= 1'b0;
    end else if (clk_en) begin
      rst_q  <= fire_w; // R1 R12
      wake_q <= wake_w; // R3
    end
  end

  // Sticky status, set wins over read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= `WDW_ST_RST;
    end else if (clk_en) begin
      if (access_w && !pwrite && hit_stat) begin
        st_q <= (st_q & ~rd_clr_q) | ev_w;
      end else begin
        st_q <= st_q | ev_w;
      end
    end
  end

  // Mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= `WDW_ST_RST;
    end else if (wr_w && hit_mask) begin
      mask_q <= pwdata[`WDW_ST_W-1:0];
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q  <= 32'h0000_0000;
      rd_clr_q <= `WDW_ST_RST;
    end else if (setup_w) begin
      rdata_q  <= pwrite ? 32'h0000_0000 : rd_w;
      rd_clr_q <= hit_stat ? st_q : `WDW_ST_RST;
    end
  end

  // Outputs
  assign pready        = clk_en;
  assign pslverr       = access_w & bad_w;
  assign prdata        = rdata_q;
  assign device_reset_req = rst_q;
  assign wake_req      = wake_q;
  assign irq           = |(st_q & mask_q);

  // Reference tick count since the last restart, for the period checks
  logic [31:0] ref_ticks_q;
  wire  [4:0]  ref_ps_w   = (shadow_q > `WDW_PS_CAP) ?
                            `WDW_PS_CAP + 5'h01 : shadow_q;
  wire  [31:0] ref_last_w = ((32'(`WDW_PRE_MAX) + 32'h1) << ref_ps_w)
                            - 32'h1;

  // Counts ticks apart from the split prescale and postscale pair
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_ticks_q <= 32'h0000_0000;
    end else if (clk_en) begin
      if (!on_w || kick_w || expire_w) begin
        ref_ticks_q <= 32'h0000_0000;
      end else if (tick_w) begin
        ref_ticks_q <= ref_ticks_q + 32'h1;
      end
    end
  end

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_expire_resets: assert property ( // R1
    clk_en && expire_w && !sleep_or_idle |=> device_reset_req
  ) else $error("expiry did not reset");

  a_sleep_wakes: assert property ( // R3
    clk_en && expire_w && sleep_or_idle
      |=> wake_req && !device_reset_req
  ) else $error("sleep expiry did not wake");

  a_early_kick: assert property ( // R12
    clk_en && kick_w && win_q && on_w && post_q < open_w
      |=> device_reset_req
  ) else $error("early kick accepted");

  a_kick_restart: assert property ( // R13
    clk_en && kick_w |=> pre_q == 5'h00 && post_q == 20'h00000
  ) else $error("kick did not restart counters");

  a_on_stop: assert property ( // R4
    $fell(on_w) |-> !cfg_on_q && $past(sw_on_q)
  ) else $error("configured watchdog stopped");

  a_ctrl_zeros: assert property ( // R10
    setup_w && !pwrite && hit_ctrl
      |=> prdata[31:16] == 16'h0000 && prdata[14:7] == 8'h00
          && !prdata[0]
  ) else $error("reserved control bits nonzero");

  a_shadow_held: assert property ( // R6
    !load_q |=> $stable(shadow_q)
  ) else $error("shadow changed after load");

  a_off_idle: assert property ( // R1
    clk_en && !on_w |=> post_q == 20'h00000 && !device_reset_req
  ) else $error("disabled watchdog counted");

  a_period_len: assert property ( // R2
    clk_en && expire_w |-> ref_ticks_q == ref_last_w
  ) else $error("timeout not at selected period");

  a_no_overrun: assert property ( // R1
    clk_en && tick_w && !kick_w && ref_ticks_q == ref_last_w
      |-> expire_w
  ) else $error("period ran past its last tick");

  c_expire: cover property (expire_w && !sleep_or_idle);
  c_wake:   cover property (wake_w);
  c_early:  cover property (early_w);
  c_inv:    cover property (ctrl_wr && hit_inv);

endmodule

// ---- logic/wdw_defines.svh ----
`ifndef WDW_DEFINES_SVH
`define WDW_DEFINES_SVH

// Register byte offsets
`define WDW_OFF_CTRL     8'h00
`define WDW_OFF_CLR      8'h04
`define WDW_OFF_SET      8'h08
`define WDW_OFF_INV      8'h0C
`define WDW_OFF_STAT     8'h10
`define WDW_OFF_MASK     8'h14

// Control register fields
`define WDW_BIT_ON       15
`define WDW_PS_HI        6
`define WDW_PS_LO        2
`define WDW_BIT_WIN      1
`define WDW_BIT_KICK     0
`define WDW_CTRL_RST     32'h0000_0000

// Status and mask fields
`define WDW_ST_W         3
`define WDW_ST_RESET     0
`define WDW_ST_WAKE      1
`define WDW_ST_EARLY     2
`define WDW_ST_RST       3'h0

// Counter shape: base prescale then 2^ps postscale
`define WDW_PRE_W        5
`define WDW_PRE_MAX      5'h1F
`define WDW_POST_W       20
`define WDW_PS_CAP       5'h13
`define WDW_WIN_SHIFT    2

`endif

// ---- logic/wdw_pkg.sv ----
package wdw_pkg;

  // One-hot write alias of the control register
  typedef enum logic [3:0] {
    WDW_AL_WR  = 4'h1,
    WDW_AL_CLR = 4'h2,
    WDW_AL_SET = 4'h4,
    WDW_AL_INV = 4'h8
  } wdw_alias_type;

endpackage

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
`include "wdw_defines.svh"

module tb_top;
  logic        pclk          = 1'b0;
  logic        presetn       = 1'b0;
  logic        clk_en        = 1'b1;
  logic        psel          = 1'b0;
  logic        penable       = 1'b0;
  logic        pwrite        = 1'b0;
  logic [7:0]  paddr         = 8'h00;
  logic [31:0] pwdata        = 32'h0;
  logic        cfg_enable    = 1'b0;
  logic [4:0]  cfg_postscale = 5'h00;
  logic        low_power_rc_tick = 1'b0;
  logic        sleep_or_idle = 1'b0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        device_reset_req;
  logic        wake_req;
  logic        irq;
  logic [31:0] rdata;
  logic        err_q;
  logic [31:0] seed;
  int          errors      = 0;
  int          comparisons = 0;
  int          rst_cnt     = 0;
  int          wake_cnt    = 0;
  int          exp_rst     = 0;
  int          exp_wake    = 0;
  int          mcnt, ps, sw, win, stat, mask;

  // Device under test
  wdw_top wdw_top_i (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cfg_enable(cfg_enable), .cfg_postscale(cfg_postscale),
    .low_power_rc_tick(low_power_rc_tick),
    .sleep_or_idle(sleep_or_idle),
    .device_reset_req(device_reset_req), .wake_req(wake_req),
    .irq(irq)
  );

  // 25 MHz clock
  always #20 pclk = ~pclk;

  // Pulse counters, sampled away from the active edge
  always @(negedge pclk) begin
    if (device_reset_req === 1'b1) rst_cnt++;
    if (wake_req === 1'b1) wake_cnt++;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected read view of the control register
  function automatic logic [31:0] view();
    return 32'((cfg_enable | sw) << 15) | 32'(ps << 2) | 32'(win << 1);
  endfunction

  task automatic end_of_test();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, waits on pready under a bound
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdata = prdata;
    err_q = pslverr;
    if (n >= 16) begin
      errors++;
      end_of_test();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Write plus model update of control, aliases and kick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    logic        k;
    int          lim;
    apb(1'b1, a, d);
    v = view();
    k = (a <= `WDW_OFF_INV) && (a != `WDW_OFF_CLR) && d[0];
    case (a)
      `WDW_OFF_CTRL: v = d;
      `WDW_OFF_CLR:  v = v & ~d;
      `WDW_OFF_SET:  v = v | d;
      `WDW_OFF_INV:  v = v ^ d;
      `WDW_OFF_MASK: mask = d[2:0];
      default: ;
    endcase
    // Kick is judged against the state before this write
    if (k && (cfg_enable | sw)) begin
      lim = (1 << ps) - 1;
      if (win && (mcnt >> 5) < lim - (lim >> 2)) begin
        exp_rst++;
        stat |= 4;
      end
      mcnt = 0;
    end
    sw  = v[15];
    win = v[1];
    if (!(cfg_enable | sw)) mcnt = 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
    if (a == `WDW_OFF_STAT) stat = 0;
  endtask

  // Oscillator ticks, model counts them and predicts pulses
  task automatic tk(input int n);
    repeat (n) begin
      low_power_rc_tick <= 1'b1;
      @(posedge pclk);
      low_power_rc_tick <= 1'b0;
      if (clk_en && (cfg_enable | sw)) mcnt++;
      if (mcnt == (32 << ps)) begin
        mcnt = 0;
        if (sleep_or_idle) begin
          exp_wake++;
          stat |= 2;
        end else begin
          exp_rst++;
          stat |= 1;
        end
      end
      @(posedge pclk);
    end
    @(posedge pclk);
    chk(rst_cnt, exp_rst);
    chk(wake_cnt, exp_wake);
  endtask

  task automatic do_reset(input logic cfg);
    presetn       <= 1'b0;
    cfg_enable    <= cfg;
    seed = lfsr(seed);
    cfg_postscale <= {3'h0, ~seed[0], seed[0]};
    ps   = 2 - int'(seed[0]);
    sw   = 0;
    win  = 0;
    stat = 0;
    mask = 0;
    mcnt = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  // Main sequence
  initial begin
    seed = 32'hDE7A24C3;
    do_reset(1'b0);
    rd(`WDW_OFF_CTRL, view());
    wr(`WDW_OFF_CTRL, 32'hFFFF_FFFE);
    rd(`WDW_OFF_CTRL, view());
    wr(`WDW_OFF_CLR, 32'h0000_8002);
    rd(`WDW_OFF_CTRL, view());
    seed = lfsr(seed);
    wr(`WDW_OFF_MASK, {29'h0, seed[2:1], 1'b1});
    wr(`WDW_OFF_SET, 32'h0000_8000);
    tk(100);
    wr(`WDW_OFF_SET, 32'h0000_0001);
    tk(100);
    tk(150);
    chk(irq, 32'((stat & mask) != 0));
    rd(`WDW_OFF_STAT, stat);
    rd(`WDW_OFF_STAT, stat);
    chk(irq, 32'h0);
    sleep_or_idle <= 1'b1;
    tk(150);
    sleep_or_idle <= 1'b0;
    wr(`WDW_OFF_SET, 32'h0000_0002);
    wr(`WDW_OFF_SET, 32'h0000_0001);
    tk(1);
    rd(`WDW_OFF_STAT, stat);
    wr(`WDW_OFF_INV, 32'h0000_0002);
    rd(`WDW_OFF_CTRL, view());
    apb(1'b0, 8'h20, 32'h0);
    chk(err_q, 32'h1);
    apb(1'b0, `WDW_OFF_CLR, 32'h0);
    chk(err_q, 32'h1);
    do_reset(1'b1);
    rd(`WDW_OFF_CTRL, view());
    wr(`WDW_OFF_CLR, 32'h0000_8000);
    rd(`WDW_OFF_CTRL, view());
    clk_en <= 1'b0;
    tk(40);
    clk_en <= 1'b1;
    tk(100);
    end_of_test();
  end
endmodule
